// ### common/instruction_format_decode_consts.svh
`ifndef INSTRUCTION_FORMAT_DECODE_CONSTS_SVH
`define INSTRUCTION_FORMAT_DECODE_CONSTS_SVH
`define ADDR_QUEUE_NEW_PSW 24'h00_0088
`define ADDR_RELOC_NEW_PSW 24'h00_0090
`define ADDR_SVC_NEW_STATUS 24'h00_0098
`define ADDR_SVC_LOC_TABLE 24'h00_009C
`define ADDR_FAULT_NEW_PSW 24'h00_00C8
`define ADDR_ISP_TABLE 24'h00_00D0
`define ADDR_ISP_LAST 24'h00_08CF
`define PSW_XLATE_BIT 21
`define FLOAT_EXP_BIAS 7'h40
`define RX3_MARK 4'h4
`define ISP_ENTRIES 12'h0400
`define RESET_STATUS 32'h0000_0000
`endif

// ### common/instruction_format_decode_pkg.sv
package instruction_format_decode_pkg;
  typedef enum logic [2:0] {
    register_pair_format,
    short_format,
    indexed_short_displacement_format,
    indexed_relative_format,
    double_indexed_format,
    halfword_immediate_format
  } format_t;
  typedef enum logic [1:0] {
    access_byte,
    access_halfword,
    access_fullword
  } access_t;
  typedef enum logic [2:0] {
    vec_none,
    vec_fault,
    vec_svc,
    vec_queue,
    vec_reloc,
    vec_isp
  } vector_t;
endpackage

// ### design/instruction_format_decode.sv
`timescale 1ns/1ps
`include "instruction_format_decode_consts.svh"
module instruction_format_decode
  import instruction_format_decode_pkg::*;
#(
  parameter int ISP_LIMIT = 1024
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // instruction stream, three halfwords
  input wire logic decode_valid,
  input wire logic [47:0] instr,
  input wire logic [23:0] instr_addr,
  // operand access check
  input wire logic access_valid,
  input wire access_t access_size,
  input wire logic [23:0] access_addr,
  input wire logic [15:0] half_operand,
  input wire logic [31:0] float_operand,
  // location counter loads
  input wire logic loc_load_valid,
  input wire logic [23:0] loc_load_value,
  // vector requests
  input wire logic vector_valid,
  input wire vector_t vector_kind,
  input wire logic [3:0] svc_index,
  input wire logic [9:0] isp_index,
  input wire logic [31:0] new_status,
  // decoded fields
  output format_t format,
  output logic [7:0] operation_code,
  output logic [3:0] first_operand_register,
  output logic [3:0] second_operand_register,
  output logic [3:0] short_immediate,
  output logic [3:0] single_index_register,
  output logic [3:0] first_index_register,
  output logic [3:0] second_index_register,
  output logic [14:0] displacement_field,
  output logic [23:0] direct_address_field,
  output logic [15:0] immediate_operand_field,
  output logic [3:0] instr_length,
  output logic decode_done,
  // operand results
  output logic [31:0] extended_operand,
  output logic [6:0] float_exponent,
  output logic float_sign,
  output logic operand_negative,
  output logic operand_zero,
  // fault and vector
  output logic data_format_fault,
  output logic [23:0] vector_addr,
  output logic vector_translate,
  output logic vector_done
);
  // the pointer table holds at most 1024 halfword entries
  if (ISP_LIMIT < 1 || ISP_LIMIT > 1024) begin : g_bad_limit
    $error("ISP_LIMIT out of range");
  end

  // ==========================================================
  // helpers
  function automatic format_t classify(input logic [15:0] second);
    if (second[15:12] == `RX3_MARK) begin
      classify = double_indexed_format;
    end else if (second[15]) begin
      classify = indexed_relative_format;
    end else begin
      classify = indexed_short_displacement_format;
    end
  endfunction

  function automatic logic misaligned(input access_t sz, input logic [23:0] a);
    case (sz)
      access_fullword: misaligned = a[1] | a[0];
      access_halfword: misaligned = a[0];
      default: misaligned = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // operand arithmetic
  logic [31:0] ext_w;
  logic [6:0] fexp_w;
  logic fsign_w;
  logic neg_w;
  logic zero_w;
  sign_extend_unit u_sext (
    .half(half_operand),
    .word(float_operand),
    .extended(ext_w),
    .float_exp(fexp_w),
    .float_sign(fsign_w),
    .float_exp_true(),
    .half_negative(neg_w),
    .half_zero(zero_w)
  );

  // ==========================================================
  // state
  typedef struct packed {
    format_t format;
    logic [7:0] op;
    logic [3:0] r1;
    logic [3:0] r2;
    logic [3:0] nimm;
    logic [3:0] x2;
    logic [3:0] fx2;
    logic [3:0] sx2;
    logic [14:0] disp;
    logic [23:0] addr;
    logic [15:0] imm;
    logic [3:0] len;
    logic done;
    logic [31:0] ext;
    logic [6:0] fexp;
    logic fsign;
    logic neg;
    logic zero;
    logic fault;
    logic [23:0] vaddr;
    logic vxlate;
    logic vdone;
  } state_t;

  state_t s;
  state_t next_s;
  logic [7:0] op_w;
  logic [15:0] second_w;

  always_comb begin
    next_s = s;
    op_w = instr[47:40];
    second_w = instr[31:16];
    next_s.done = 1'b0;
    next_s.fault = 1'b0;
    next_s.vdone = 1'b0;
    if (decode_valid) begin
      next_s.op = op_w;
      next_s.r1 = instr[39:36];
      next_s.r2 = instr[35:32];
      next_s.nimm = instr[35:32];
      next_s.x2 = instr[35:32];
      next_s.fx2 = instr[35:32];
      next_s.sx2 = second_w[11:8];
      next_s.addr = instr[23:0];
      next_s.imm = second_w;
      next_s.done = 1'b1;
      // op bits 7:6 pick the length class: 00 pair or short (op bit 5), 10 pair, 01 indexed, 11 immediate
      case (op_w[7:6])
        2'b00: begin
          next_s.format = op_w[5] ? short_format : register_pair_format;
          next_s.len = 4'h2;
        end
        2'b01: begin
          next_s.format = classify(second_w);
          next_s.len = (classify(second_w) == double_indexed_format) ? 4'h6 : 4'h4;
        end
        2'b11: begin
          next_s.format = halfword_immediate_format;
          next_s.len = 4'h4;
        end
        default: begin
          next_s.format = register_pair_format;
          next_s.len = 4'h2;
        end
      endcase
      if (second_w[15]) begin
        next_s.disp = second_w[14:0];
      end else begin
        next_s.disp = {1'b0, second_w[13:0]};
      end
      next_s.fault = instr_addr[0];
    end
    if (access_valid) begin
      next_s.ext = ext_w;
      next_s.neg = neg_w;
      next_s.zero = zero_w;
      next_s.fexp = fexp_w;
      next_s.fsign = fsign_w;
      if (misaligned(access_size, access_addr)) begin
        next_s.fault = 1'b1;
      end
    end
    if (loc_load_valid && loc_load_value[0]) begin
      next_s.fault = 1'b1;
    end
    if (vector_valid) begin
      next_s.vdone = 1'b1;
      next_s.vxlate = 1'b0;
      case (vector_kind)
        vec_fault: next_s.vaddr = `ADDR_FAULT_NEW_PSW;
        vec_svc: begin
          next_s.vaddr = `ADDR_SVC_LOC_TABLE + {19'h0_0000, svc_index, 1'b0};
          next_s.vxlate = new_status[31 - `PSW_XLATE_BIT];
        end
        vec_queue: next_s.vaddr = `ADDR_QUEUE_NEW_PSW;
        vec_reloc: next_s.vaddr = `ADDR_RELOC_NEW_PSW;
        vec_isp: next_s.vaddr = `ADDR_ISP_TABLE + {13'h0000, isp_index, 1'b0};
        default: next_s.vaddr = `ADDR_SVC_NEW_STATUS;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign format = s.format;
  assign operation_code = s.op;
  assign first_operand_register = s.r1;
  assign second_operand_register = s.r2;
  assign short_immediate = s.nimm;
  assign single_index_register = s.x2;
  assign first_index_register = s.fx2;
  assign second_index_register = s.sx2;
  assign displacement_field = s.disp;
  assign direct_address_field = s.addr;
  assign immediate_operand_field = s.imm;
  assign instr_length = s.len;
  assign decode_done = s.done;
  assign extended_operand = s.ext;
  assign float_exponent = s.fexp;
  assign float_sign = s.fsign;
  assign operand_negative = s.neg;
  assign operand_zero = s.zero;
  assign data_format_fault = s.fault;
  assign vector_addr = s.vaddr;
  assign vector_translate = s.vxlate;
  assign vector_done = s.vdone;

  // ==========================================================
  // assertions
  a_fullword_align: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid && access_size == access_fullword && access_addr[1:0] != 2'b00
    |=> data_format_fault) else $error("fullword misalignment missed");
  a_halfword_align: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid && access_size == access_halfword && access_addr[0]
    |=> data_format_fault) else $error("halfword misalignment missed");
  a_odd_loc: assert property (@(posedge clock) disable iff (!rst_n)
    loc_load_valid && loc_load_value[0] |=> data_format_fault)
    else $error("odd location counter missed");
  a_no_spurious: assert property (@(posedge clock) disable iff (!rst_n)
    !access_valid && !loc_load_valid && !(decode_valid && instr_addr[0])
    |=> !data_format_fault) else $error("spurious fault");
  a_sign_ext: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid |=> extended_operand == {{16{$past(half_operand[15])}},
    $past(half_operand)}) else $error("sign extension wrong");
  a_fault_vec: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_fault
    |=> vector_addr == 24'h00_00C8 && !vector_translate) else $error("fault vector wrong");
  a_svc_vec: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_svc |=> vector_addr >= 24'h00_009C
    && vector_addr <= 24'h00_00BA) else $error("svc vector out of table");
  a_isp_range: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_isp |=> vector_addr >= 24'h00_00D0
    && vector_addr <= 24'h00_08CF) else $error("isp vector out of table");
  a_rx3_decode: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:46] == 2'b01 && instr[31:28] == 4'h4
    |=> format == double_indexed_format && instr_length == 4'h6)
    else $error("double indexed decode wrong");
  a_opcode: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid |=> operation_code == $past(instr[47:40])) else $error("opcode wrong");
  a_first_reg: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid |=> first_operand_register == $past(instr[39:36]))
    else $error("first register wrong");

  // ==========================================================
  // per-format field checks and the odd instruction address fault
  a_pair_fields: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:45] == 3'b000
    |=> format == register_pair_format && instr_length == 4'h2
    && second_operand_register == $past(instr[35:32])) else $error("pair format wrong");
  a_short_imm: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:45] == 3'b001
    |=> format == short_format && short_immediate == $past(instr[35:32]))
    else $error("short immediate wrong");
  a_rx1_disp: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:46] == 2'b01 && instr[31:30] == 2'b00
    |=> format == indexed_short_displacement_format
    && displacement_field == {1'b0, $past(instr[29:16])}
    && single_index_register == $past(instr[35:32])) else $error("short displacement wrong");
  a_rx2_disp: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:46] == 2'b01 && instr[31]
    |=> format == indexed_relative_format && displacement_field == $past(instr[30:16]))
    else $error("relative displacement wrong");
  a_rx3_fields: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:46] == 2'b01 && instr[31:28] == 4'h4
    |=> second_index_register == $past(instr[27:24])
    && direct_address_field == $past(instr[23:0])) else $error("double index fields wrong");
  a_ri1_fields: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr[47:46] == 2'b11
    |=> format == halfword_immediate_format && instr_length == 4'h4
    && immediate_operand_field == $past(instr[31:16])) else $error("immediate format wrong");
  a_odd_instr: assert property (@(posedge clock) disable iff (!rst_n)
    decode_valid && instr_addr[0] |=> data_format_fault)
    else $error("odd instruction address missed");

  // ==========================================================
  // operand checks
  a_sign_flags: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid |=> operand_negative == $past(half_operand[15])
    && operand_zero == ($past(half_operand) == 16'h0000)) else $error("sign flags wrong");
  a_float_fields: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid |=> {float_sign, float_exponent} == $past(float_operand[31:24]))
    else $error("float fields wrong");
  a_byte_free: assert property (@(posedge clock) disable iff (!rst_n)
    access_valid && access_size == access_byte && !loc_load_valid && !decode_valid
    |=> !data_format_fault) else $error("byte access faulted");

  // ==========================================================
  // vector checks
  a_svc_xlate: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_svc |=> vector_translate == $past(new_status[10]))
    else $error("svc translation wrong");
  a_other_abs: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind != vec_svc |=> !vector_translate)
    else $error("absolute pointer translated");
  a_queue_vec: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_queue |=> vector_addr == 24'h00_0088)
    else $error("queue vector wrong");
  a_reloc_vec: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid && vector_kind == vec_reloc |=> vector_addr == 24'h00_0090)
    else $error("relocation vector wrong");
  a_vec_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    vector_valid |=> vector_done) else $error("vector done missing");

  // ==========================================================
  // covers
  c_rx2: cover property (@(posedge clock) decode_done && format == indexed_relative_format);
  c_rr: cover property (@(posedge clock) decode_done && format == register_pair_format);
  c_rx3: cover property (@(posedge clock) decode_done && format == double_indexed_format);
  c_fault: cover property (@(posedge clock) data_format_fault);
  c_svc: cover property (@(posedge clock) vector_done && vector_translate);
endmodule

// ### design/sign_extend_unit.sv
`timescale 1ns/1ps
`include "instruction_format_decode_consts.svh"
module sign_extend_unit
  import instruction_format_decode_pkg::*;
(
  // operand in
  input wire logic [15:0] half,
  input wire logic [31:0] word,
  // results
  output logic [31:0] extended,
  output logic [6:0] float_exp,
  output logic float_sign,
  output logic [7:0] float_exp_true,
  output logic half_negative,
  output logic half_zero
);
  always_comb begin
    extended = {{16{half[15]}}, half};
    half_negative = half[15];
    half_zero = (half == 16'h0000);
    float_sign = word[31];
    float_exp = word[30:24];
    float_exp_true = {1'b0, word[30:24]} - {1'b0, `FLOAT_EXP_BIAS};
  end
endmodule

// ### tb/instruction_format_decode_bench.sv
`timescale 1ns/1ps
module instruction_format_decode_bench;
  import instruction_format_decode_pkg::*;
  logic clock = 0;
  logic rst_n = 0;
  logic decode_valid, access_valid, loc_load_valid, vector_valid;
  logic [47:0] instr, fetch_word, w;
  logic [23:0] instr_addr, access_addr, loc_load_value, vector_addr, fetch_addr;
  access_t access_size;
  vector_t vector_kind;
  logic [15:0] half_operand, immediate_operand_field;
  logic [31:0] float_operand, new_status, extended_operand, seed;
  logic [3:0] svc_index, first_operand_register, second_operand_register, short_immediate;
  logic [3:0] single_index_register, first_index_register, second_index_register, instr_length;
  logic [9:0] isp_index;
  format_t format;
  logic [7:0] operation_code;
  logic [14:0] displacement_field;
  logic [23:0] direct_address_field;
  logic [6:0] float_exponent;
  logic decode_done, float_sign, operand_negative, operand_zero;
  logic data_format_fault, vector_translate, vector_done;
  int n_errors = 0;
  int n_checks = 0;
  instruction_format_decode dut (.clock, .rst_n, .decode_valid, .instr, .instr_addr,
    .access_valid, .access_size, .access_addr, .half_operand, .float_operand,
    .loc_load_valid, .loc_load_value, .vector_valid, .vector_kind, .svc_index, .isp_index,
    .new_status, .format, .operation_code, .first_operand_register,
    .second_operand_register, .short_immediate, .single_index_register,
    .first_index_register, .second_index_register, .displacement_field,
    .direct_address_field, .immediate_operand_field, .instr_length, .decode_done,
    .extended_operand, .float_exponent, .float_sign, .operand_negative, .operand_zero,
    .data_format_fault, .vector_addr, .vector_translate, .vector_done);
  main_memory_model mem (.fetch_addr, .fetch_word);
  initial forever #2.5 clock = ~clock;
  // ==========
  // helpers
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [23:0] vexp(input vector_t k, input logic [3:0] s, input logic [9:0] i);
    case (k)
      vec_fault: return 24'h00_00c8;
      vec_queue: return 24'h00_0088;
      vec_reloc: return 24'h00_0090;
      vec_svc: return 24'h00_009c + {19'h0_0000, s, 1'b0};
      vec_isp: return 24'h00_00d0 + {13'h0000, i, 1'b0};
      default: return 24'h00_0098;
    endcase
  endfunction
  task finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one edge takes the request, outputs settle after it
  task step;
    @(posedge clock);
    decode_valid <= 0;
    access_valid <= 0;
    loc_load_valid <= 0;
    vector_valid <= 0;
    #1;
  endtask
  task dec(input logic [23:0] a, input logic [47:0] v);
    format_t f;
    @(posedge clock);
    decode_valid <= 1;
    instr <= v;
    instr_addr <= a;
    step;
    f = v[47:46] == 2'b11 ? halfword_immediate_format : v[47:46] == 2'b01 ?
      (v[31:28] == 4'h4 ? double_indexed_format : v[31] ? indexed_relative_format :
      indexed_short_displacement_format) : (v[47:45] == 3'b001 ? short_format :
      register_pair_format);
    chk(decode_done, 1);
    chk(data_format_fault, a[0]);
    chk(format, f);
    chk({operation_code, first_operand_register}, v[47:36]);
    chk(instr_length, f == double_indexed_format ? 6 : v[47:46] == 2'b01 ||
      f == halfword_immediate_format ? 4 : 2);
    case (f)
      register_pair_format: chk(second_operand_register, v[35:32]);
      short_format: chk(short_immediate, v[35:32]);
      halfword_immediate_format: chk({single_index_register, immediate_operand_field},
        v[35:16]);
      double_indexed_format: chk({first_index_register, second_index_register,
        direct_address_field}, {v[35:32], v[27:24], v[23:0]});
      indexed_relative_format: chk({single_index_register, displacement_field},
        {v[35:32], v[30:16]});
      default: chk({single_index_register, displacement_field},
        {v[35:32], 1'b0, v[29:16]});
    endcase
  endtask
  task acc(input access_t s, input logic [23:0] a, input logic [15:0] h, input logic [31:0] fl);
    logic e;
    @(posedge clock);
    access_valid <= 1;
    access_size <= s;
    access_addr <= a;
    half_operand <= h;
    float_operand <= fl;
    step;
    e = s == access_fullword ? |a[1:0] : s == access_halfword && a[0];
    chk(data_format_fault, e);
    chk(extended_operand, {{16{h[15]}}, h});
    chk({operand_negative, operand_zero}, {h[15], h == 16'h0000});
    chk({float_sign, float_exponent}, fl[31:24]);
  endtask
  task vec(input vector_t k, input logic [3:0] s, input logic [9:0] i, input logic [31:0] st);
    @(posedge clock);
    vector_valid <= 1;
    vector_kind <= k;
    svc_index <= s;
    isp_index <= i;
    new_status <= st;
    step;
    chk({vector_done, data_format_fault}, 2'b10);
    chk(vector_addr, vexp(k, s, i));
    chk(vector_translate, k == vec_svc && st[10]);
  endtask
  // ==========
  // main sequence
  initial begin
    {decode_valid, access_valid, loc_load_valid, vector_valid} = 0;
    {instr, instr_addr, access_addr, loc_load_value, fetch_addr} = 0;
    {half_operand, float_operand, new_status, svc_index, isp_index} = 0;
    access_size = access_byte;
    vector_kind = vec_none;
    seed = 32'h0000_502e;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    #1;
    chk({format, decode_done, vector_addr, data_format_fault}, 0);
    for (int a = 0; a < 44; a += 2) begin
      fetch_addr = 24'(a);
      #1;
      dec(24'(a), fetch_word);
    end
    for (int s = 0; s < 3; s++)
      for (int a = 0; a < 8; a++)
        acc(access_t'(s), 24'(a), {16{a[0]}} ^ {a[1], 15'h0000}, {a[0], 7'(a * 9), 24'h00_0000});
    for (int k = 0; k < 6; k++)
      vec(vector_t'(k), 4'hf, 10'h3ff, 32'h0000_0400);
    vec(vec_isp, 4'h0, 10'h000, 32'hffff_ffff);
    for (int i = 0; i < 150; i++) begin
      seed = lfsr(seed);
      w[47:16] = seed;
      seed = lfsr(seed);
      w[15:0] = seed[31:16];
      if (w[47:46] == 2'b01 && w[31:30] == 2'b01)
        w[29:28] = 2'b00;
      dec(seed[23:0], w);
      acc(access_t'(seed[1:0] % 2'd3), w[23:0], seed[15:0], w[31:0]);
      @(posedge clock);
      loc_load_valid <= 1;
      loc_load_value <= seed[27:4];
      step;
      chk(data_format_fault, seed[4]);
      vec(vector_t'(3'(i % 6)), seed[3:0], w[9:0], w[31:0]);
    end
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test;
  end
endmodule

// ### tb/main_memory_model.sv
`timescale 1ns/1ps
module main_memory_model (
  // fetch port
  input wire logic [23:0] fetch_addr,
  output logic [47:0] fetch_word
);
  // ==========
  // program image, padded with a pattern so stale zeros never pass
  logic [0:31][15:0] mem = {16'h245e, 16'h0865, 16'h4050, 16'h1000, 16'h4056, 16'h0ff2,
    16'h4050, 16'h8004, 16'h4300, 16'h8004, 16'h0000, 16'h0000, 16'hc890, 16'h8000,
    16'hc895, 16'h8000, 16'h5870, 16'h4001, 16'h0000, 16'h5885, 16'h4601, 16'hffe4,
    {10{16'ha5a5}}};
  logic [4:0] hw;
  assign hw = fetch_addr[5:1];
  // three halfwords from any even start
  assign fetch_word = {mem[hw], mem[hw + 5'h01], mem[hw + 5'h02]};
endmodule
